// ### pci_term_pkg.sv
package pci_term_pkg;

    // Configuration word offsets (byte addresses)
    localparam logic [7:0] OFS_IDENT = 8'h00;
    localparam logic [7:0] OFS_CMD_STAT = 8'h04;

    // Bus commands seen on the command/byte-enable lines
    localparam logic [3:0] CMD_MEM_RD = 4'h6;
    localparam logic [3:0] CMD_MEM_WR = 4'h7;
    localparam logic [3:0] CMD_CFG_RD = 4'ha;
    localparam logic [3:0] CMD_CFG_WR = 4'hb;

    // Command half field positions
    localparam int unsigned BIT_MEM_EN = 1;
    localparam int unsigned BIT_MST_EN = 2;
    localparam int unsigned BIT_PAR_EN = 6;
    localparam int unsigned BIT_SERR_EN = 8;

    // Status half field positions
    localparam int unsigned BIT_FBB_TGT = 23;
    localparam int unsigned BIT_PAR_RPT = 24;
    localparam int unsigned BIT_DTS0 = 25;
    localparam int unsigned BIT_TARGET_ABORT_SIGNALLED_SIG = 27;
    localparam int unsigned BIT_TARGET_ABORT_SIGNALLED_MST = 28;
    localparam int unsigned BIT_MABT = 29;
    localparam int unsigned BIT_SERR_RPT = 30;
    localparam int unsigned BIT_PAR_DET = 31;

    // Reset value of every writable bit
    localparam logic [31:0] CMD_STAT_RST = 32'h0000_0000;

    // Idle clocks before a master retries after a disconnect
    localparam logic [1:0] RETRY_WAIT_NODATA = 2'h1;
    localparam logic [1:0] RETRY_WAIT_DATA = 2'h2;

    // Byte enable patterns (active low) the local bus can carry
    localparam logic [3:0] BE_ALL = 4'h0;
    localparam logic [3:0] BE_NONE = 4'hf;
    localparam logic [3:0] BE_LOW_HALF = 4'hc;
    localparam logic [3:0] BE_HIGH_HALF = 4'h3;

    // Target sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SKIP = 3'b001,
        ST_WAIT = 3'b010,
        ST_CLAIM = 3'b011,
        ST_XFER = 3'b100,
        ST_STOP = 3'b101,
        ST_TURN = 3'b110
    } tgt_state_e;

    // One memory-space access handed to the user side
    typedef struct packed {
        logic write;
        logic local_bus;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [3:0] byte_en_n;
    } mem_req_s;

    // Target control outputs, all active low, plus their shared enable
    typedef struct packed {
        logic devsel_n;
        logic trdy_n;
        logic stop_n;
        logic drive;
    } tgt_ctl_s;

endpackage

// ### pci_term_cfg.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Stop released once initiator drops frame
// - Burst to target disconnects after first data
// - Master retries after one or two clocks
// - Target abort: stop asserted as devsel drops
// - Abort only unsupported local-bus byte enables
// - Target-abort-signalled flag conflicts; reads zero
// - Master seeing target abort sets flag
// - No master fast back-to-back; target accepts both
// - Identification word fixed, read-only
// - Zero command half: only configuration accesses
// - Status bits clear on one, never set
// - Memory enable gates memory accesses; reset clear
// - Master enable gates bus mastering; reset clear
// - Parity response enable gates parity action
// - System error enable gates system-error pin
// - Fixed command bits read zero, ignore writes
// - Master target-abort flag sticky at bit 28
module pci_term_cfg #(
    parameter logic [15:0] VENDOR_CODE = 16'h1a2b, // Arbitrary value
    parameter logic [15:0] DEVICE_CODE = 16'h5c6d, // Arbitrary value
    parameter logic [31:0] REG_BASE = 32'h0000_0000,
    parameter logic [31:0] REG_MASK = 32'hffff_f000,
    parameter logic [31:0] LB_BASE = 32'h0010_0000,
    parameter logic [31:0] LB_MASK = 32'hfff0_0000
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // Bus address/data, two-way
    input wire logic [31:0] bus_ad_i,
    output logic [31:0] bus_ad_o,
    output logic bus_ad_oe_o,
    // Bus control inputs
    input wire logic [3:0] bus_cmd_byte_en_n_i,
    input wire logic bus_frame_n_i,
    input wire logic bus_initiator_ready_n_i,
    input wire logic bus_idsel_i,
    // Target control, sustained three-state
    output logic bus_devsel_n_o,
    output logic bus_target_ready_n_o,
    output logic bus_stop_n_o,
    output logic bus_tgt_ctl_oe_o,
    // System error, open drain
    output logic bus_system_error_n_o,
    output logic bus_system_error_oe_o,
    // Events from the master engine and the parity checker
    input wire logic mst_active_i,
    input wire logic mst_target_abort_i,
    input wire logic mst_master_abort_i,
    input wire logic mst_disconnect_i,
    input wire logic mst_disc_with_data_i,
    input wire logic bus_grant_n_i,
    input wire logic parity_err_i,
    input wire logic sys_err_req_i,
    // Master engine control
    output logic mst_allowed_o,
    output logic mst_retry_o,
    output logic parity_act_o,
    // Memory-space user side
    output pci_term_pkg::mem_req_s mem_req_o,
    output logic mem_req_valid_o,
    input wire logic [31:0] mem_rdata_i
);

    // Sequencer state and registered target controls
    pci_term_pkg::tgt_state_e st, next_st;
    pci_term_pkg::tgt_ctl_s ctl, next_ctl;
    logic [31:0] addr, next_addr; // Captured address
    logic [3:0] cmd, next_cmd; // Captured bus command
    logic is_cfg, next_is_cfg; // Access is a configuration cycle
    logic is_lb, next_is_lb; // Access targets the local bus
    logic [31:0] rdata, next_rdata; // Read data driven onto the bus
    logic ad_oe, next_ad_oe; // Read data drive enable
    logic req_v, next_req_v; // One-cycle memory request pulse
    pci_term_pkg::mem_req_s req, next_req;

    // Command and status state
    logic [31:0] cs, next_cs;
    logic serr_drv, next_serr_drv;
    logic par_act, next_par_act;
    logic [1:0] rwait, next_rwait; // Retry wait countdown
    logic rpend, next_rpend; // Retry waiting on countdown
    logic retry, next_retry;

    // Combinational decode helpers
    logic cmd_all_zero;
    logic mem_en;
    logic cfg_hit;
    logic reg_hit;
    logic lb_hit;
    logic mem_cmd; // Memory read or write command on the bus
    logic xfer_done;
    logic is_write;
    logic [31:0] cfg_rd;
    logic [31:0] be_mask;

    // Local bus takes full word, either half, single byte or no byte
    function automatic logic lb_be_ok(input logic [3:0] be_n);
        lb_be_ok = (be_n == pci_term_pkg::BE_ALL) ||
                   (be_n == pci_term_pkg::BE_NONE) ||
                   (be_n == pci_term_pkg::BE_LOW_HALF) ||
                   (be_n == pci_term_pkg::BE_HIGH_HALF) ||
                   ($countones(~be_n) == 1);
    endfunction

    // Address phase decode, also used right after a transfer
    always_comb begin
        cmd_all_zero = (cs[15:0] == 16'h0000);
        mem_en = cs[pci_term_pkg::BIT_MEM_EN] && !cmd_all_zero;
        cfg_hit = bus_idsel_i &&
                  (bus_cmd_byte_en_n_i == pci_term_pkg::CMD_CFG_RD ||
                   bus_cmd_byte_en_n_i == pci_term_pkg::CMD_CFG_WR);
        mem_cmd = bus_cmd_byte_en_n_i == pci_term_pkg::CMD_MEM_RD ||
                  bus_cmd_byte_en_n_i == pci_term_pkg::CMD_MEM_WR;
        reg_hit = mem_en && mem_cmd &&
                  ((bus_ad_i & REG_MASK) == REG_BASE);
        lb_hit = mem_en && mem_cmd && ((bus_ad_i & LB_MASK) == LB_BASE);
        xfer_done = !bus_initiator_ready_n_i && !ctl.trdy_n;
        is_write = (cmd == pci_term_pkg::CMD_CFG_WR) ||
                   (cmd == pci_term_pkg::CMD_MEM_WR);
        be_mask = {{8{!bus_cmd_byte_en_n_i[3]}}, {8{!bus_cmd_byte_en_n_i[2]}},
                   {8{!bus_cmd_byte_en_n_i[1]}}, {8{!bus_cmd_byte_en_n_i[0]}}};
    end

    // Configuration read mux; unmapped words read zero
    always_comb begin
        cfg_rd = 32'h0000_0000;
        if (addr[7:0] == pci_term_pkg::OFS_IDENT) begin
            cfg_rd = {DEVICE_CODE, VENDOR_CODE};
        end else if (addr[7:0] == pci_term_pkg::OFS_CMD_STAT) begin
            cfg_rd = cs;
        end
    end

    // Target sequencer: next state and next outputs
    always_comb begin
        next_st = st;
        next_ctl = ctl;
        next_addr = addr;
        next_cmd = cmd;
        next_is_cfg = is_cfg;
        next_is_lb = is_lb;
        next_rdata = rdata;
        next_ad_oe = ad_oe;
        next_req_v = 1'b0;
        next_req = req;
        case (st)
            pci_term_pkg::ST_IDLE, pci_term_pkg::ST_TURN: begin
                // Release the controls, drop the enable a cycle later
                next_ctl = '{devsel_n: 1'b1, trdy_n: 1'b1, stop_n: 1'b1,
                             drive: 1'b0};
                next_ad_oe = 1'b0;
                next_st = pci_term_pkg::ST_IDLE;
                // TURN decodes too, so a new address phase right
                // after our last data phase is not missed
                if (!bus_frame_n_i) begin
                    next_addr = bus_ad_i;
                    next_cmd = bus_cmd_byte_en_n_i;
                    next_is_cfg = cfg_hit;
                    next_is_lb = lb_hit && !reg_hit;
                    if (cfg_hit || reg_hit || lb_hit) begin
                        next_st = pci_term_pkg::ST_WAIT;
                    end else begin
                        next_st = pci_term_pkg::ST_SKIP;
                    end
                end
            end
            pci_term_pkg::ST_SKIP: begin
                // Not ours: wait for the initiator's last data phase
                if (bus_frame_n_i) begin
                    next_st = pci_term_pkg::ST_IDLE;
                end
            end
            pci_term_pkg::ST_WAIT: begin
                // Medium decode timing: claim one clock later
                next_ctl = '{devsel_n: 1'b0, trdy_n: 1'b1, stop_n: 1'b1,
                             drive: 1'b1};
                next_st = pci_term_pkg::ST_CLAIM;
            end
            pci_term_pkg::ST_CLAIM: begin
                // Byte enables are stable once the initiator is ready
                if (!bus_initiator_ready_n_i) begin
                    if (is_lb && !lb_be_ok(bus_cmd_byte_en_n_i)) begin
                        next_ctl = '{devsel_n: 1'b1, trdy_n: 1'b1,
                                     stop_n: 1'b0, drive: 1'b1};
                        next_st = pci_term_pkg::ST_STOP;
                    end else begin
                        // Burst still running: stop rides with data
                        next_ctl = '{devsel_n: 1'b0, trdy_n: 1'b0,
                                     stop_n: bus_frame_n_i,
                                     drive: 1'b1};
                        next_rdata = is_cfg ? cfg_rd : mem_rdata_i;
                        next_ad_oe = !is_write;
                        next_st = pci_term_pkg::ST_XFER;
                    end
                end
            end
            pci_term_pkg::ST_XFER: begin
                if (xfer_done) begin
                    next_ad_oe = 1'b0;
                    if (!is_cfg) begin
                        next_req_v = 1'b1;
                        next_req = '{write: is_write, local_bus: is_lb,
                                     addr: addr, wdata: bus_ad_i,
                                     byte_en_n: bus_cmd_byte_en_n_i};
                    end
                    if (bus_frame_n_i) begin
                        next_ctl = '{devsel_n: 1'b1, trdy_n: 1'b1,
                                     stop_n: 1'b1, drive: 1'b1};
                        next_st = pci_term_pkg::ST_TURN;
                    end else begin
                        // Only one data phase accepted per transaction
                        next_ctl = '{devsel_n: 1'b0, trdy_n: 1'b1,
                                     stop_n: 1'b0, drive: 1'b1};
                        next_st = pci_term_pkg::ST_STOP;
                    end
                end
            end
            pci_term_pkg::ST_STOP: begin
                // Hold stop until frame goes away, then release
                if (bus_frame_n_i) begin
                    next_ctl = '{devsel_n: 1'b1, trdy_n: 1'b1, stop_n: 1'b1,
                                 drive: 1'b1};
                    next_st = pci_term_pkg::ST_TURN;
                end
            end
            default: begin
                next_st = pci_term_pkg::ST_IDLE;
            end
        endcase
    end

    // Target sequencer registers
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st <= pci_term_pkg::ST_IDLE;
            ctl <= '{devsel_n: 1'b1, trdy_n: 1'b1, stop_n: 1'b1,
                     drive: 1'b0};
            addr <= 32'h0000_0000;
            cmd <= 4'h0;
            is_cfg <= 1'b0;
            is_lb <= 1'b0;
            rdata <= 32'h0000_0000;
            ad_oe <= 1'b0;
            req_v <= 1'b0;
            req <= '0;
        end else begin
            st <= next_st;
            ctl <= next_ctl;
            addr <= next_addr;
            cmd <= next_cmd;
            is_cfg <= next_is_cfg;
            is_lb <= next_is_lb;
            rdata <= next_rdata;
            ad_oe <= next_ad_oe;
            req_v <= next_req_v;
            req <= next_req;
        end
    end

    // Command/status, error pins and master retry timing
    always_comb begin
        next_cs = cs;
        // Software writes land on the completed config data phase
        if (st == pci_term_pkg::ST_XFER && xfer_done && is_cfg &&
            cmd == pci_term_pkg::CMD_CFG_WR &&
            addr[7:0] == pci_term_pkg::OFS_CMD_STAT) begin
            // Command half; read-only bits are forced back to zero below
            next_cs[15:0] = (cs[15:0] & ~be_mask[15:0]) |
                            (bus_ad_i[15:0] & be_mask[15:0]);
            // Writing one clears a status bit, zero leaves it
            next_cs[31:24] = cs[31:24] & ~(bus_ad_i[31:24] & be_mask[31:24]);
        end
        // Hardware events set afterwards, so a set wins over a clear
        if (mst_active_i && mst_target_abort_i) begin
            next_cs[pci_term_pkg::BIT_TARGET_ABORT_SIGNALLED_MST] = 1'b1;
        end
        if (mst_active_i && mst_master_abort_i) begin
            next_cs[pci_term_pkg::BIT_MABT] = 1'b1;
        end
        if (mst_active_i && parity_err_i && cs[pci_term_pkg::BIT_PAR_EN]) begin
            next_cs[pci_term_pkg::BIT_PAR_RPT] = 1'b1;
        end
        if (parity_err_i) begin
            next_cs[pci_term_pkg::BIT_PAR_DET] = 1'b1;
        end
        if (sys_err_req_i) begin
            next_cs[pci_term_pkg::BIT_SERR_RPT] = 1'b1;
        end
        // Fixed fields, never writable
        next_cs[0] = 1'b0;
        next_cs[5:3] = 3'h0;
        next_cs[7] = 1'b0;
        next_cs[23:9] = 15'h0000;
        next_cs[pci_term_pkg::BIT_FBB_TGT] = 1'b1;
        next_cs[pci_term_pkg::BIT_DTS0 + 1:pci_term_pkg::BIT_DTS0] = 2'h1;
        // Never issued as a target abort report; see hand-over
        next_cs[pci_term_pkg::BIT_TARGET_ABORT_SIGNALLED_SIG] = 1'b0;

        // Error pin drives low only while enabled
        next_serr_drv = sys_err_req_i && cs[pci_term_pkg::BIT_SERR_EN];
        next_par_act = parity_err_i && cs[pci_term_pkg::BIT_PAR_EN];

        // Retry countdown after a master-side disconnect
        next_rwait = rwait;
        next_rpend = rpend;
        next_retry = 1'b0;
        if (mst_disconnect_i) begin
            next_rpend = 1'b1;
            next_rwait = mst_disc_with_data_i ? pci_term_pkg::RETRY_WAIT_DATA
                                              : pci_term_pkg::RETRY_WAIT_NODATA;
        end else if (rpend) begin
            if (rwait > 2'h1) begin
                next_rwait = rwait - 2'h1;
            end else begin
                // Retry only if the grant survived the wait
                next_rpend = 1'b0;
                next_rwait = 2'h0;
                next_retry = !bus_grant_n_i &&
                             cs[pci_term_pkg::BIT_MST_EN];
            end
        end
    end

    // Command/status registers
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cs <= pci_term_pkg::CMD_STAT_RST;
            serr_drv <= 1'b0;
            par_act <= 1'b0;
            rwait <= 2'h0;
            rpend <= 1'b0;
            retry <= 1'b0;
        end else begin
            cs <= next_cs;
            serr_drv <= next_serr_drv;
            par_act <= next_par_act;
            rwait <= next_rwait;
            rpend <= next_rpend;
            retry <= next_retry;
        end
    end

    // Pin and user outputs
    assign bus_ad_o = rdata;
    assign bus_ad_oe_o = ad_oe;
    assign bus_devsel_n_o = ctl.devsel_n;
    assign bus_target_ready_n_o = ctl.trdy_n;
    assign bus_stop_n_o = ctl.stop_n;
    assign bus_tgt_ctl_oe_o = ctl.drive;
    assign bus_system_error_n_o = 1'b0;
    assign bus_system_error_oe_o = serr_drv;
    // Master has no fast back-to-back path; enable gates it entirely
    assign mst_allowed_o = cs[pci_term_pkg::BIT_MST_EN];
    assign mst_retry_o = retry;
    assign parity_act_o = par_act;
    assign mem_req_o = req;
    assign mem_req_valid_o = req_v;

endmodule // pci_term_cfg
`default_nettype wire

// ### pci_term_cfg_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// Timing relations at the target and master-control ports
module pci_term_cfg_checker (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // Bus side
    input wire logic bus_frame_n_i,
    input wire logic bus_initiator_ready_n_i,
    input wire logic bus_devsel_n_o,
    input wire logic bus_target_ready_n_o,
    input wire logic bus_stop_n_o,
    input wire logic bus_system_error_oe_o,
    // Master engine and user side
    input wire logic mst_disconnect_i,
    input wire logic mst_disc_with_data_i,
    input wire logic bus_grant_n_i,
    input wire logic mst_allowed_o,
    input wire logic mst_retry_o,
    input wire logic parity_err_i,
    input wire logic sys_err_req_i,
    input wire logic parity_act_o,
    input wire logic mem_req_valid_o
);
    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (!arst_n_i);
    // Abort: stop falls while devsel is let go
    sequence abort_s;
        $fell(bus_stop_n_o) && bus_devsel_n_o;
    endsequence
    // A disconnect that may be retried; wd picks the kind
    sequence disc_s(logic wd);
        mst_disconnect_i && (mst_disc_with_data_i == wd) &&
            !bus_grant_n_i && mst_allowed_o;
    endsequence
    stop_release_a: assert property (
        !bus_stop_n_o && bus_frame_n_i |=> bus_stop_n_o)
        else $error("stop held after frame went high");
    burst_disc_a: assert property (
        !bus_target_ready_n_o && !bus_initiator_ready_n_i &&
            !bus_frame_n_i |-> !bus_stop_n_o)
        else $error("burst data phase without stop");
    retry_one_a: assert property (
        disc_s(1'b0) |=> !mst_retry_o ##[1:2] mst_retry_o)
        else $error("retry after plain disconnect mistimed");
    retry_two_a: assert property (
        disc_s(1'b1) |=> !mst_retry_o[*2] ##[1:2] mst_retry_o)
        else $error("retry after data disconnect mistimed");
    abort_nodata_a: assert property (
        abort_s |-> bus_target_ready_n_o ##1 !mem_req_valid_o[*3])
        else $error("data moved on an abort");
    mem_xfer_a: assert property (
        mem_req_valid_o |->
            $past(!bus_target_ready_n_o && !bus_initiator_ready_n_i))
        else $error("memory request without a data phase");
    parity_cause_a: assert property (
        parity_act_o |-> $past(parity_err_i))
        else $error("parity action without parity error");
    serr_cause_a: assert property (
        $rose(bus_system_error_oe_o) |-> $past(sys_err_req_i))
        else $error("system error pin without request");
endmodule // pci_term_cfg_checker

bind pci_term_cfg pci_term_cfg_checker i_pci_term_cfg_checker (.*);
`default_nettype wire

// ### pci_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural initiator on the far side of the bus
module pci_host_model (
    // Clock and target answers
    input wire logic mclk_i,
    input wire logic bus_devsel_n_i,
    input wire logic bus_target_ready_n_i,
    input wire logic bus_stop_n_i,
    input wire logic bus_tgt_ctl_oe_i,
    input wire logic [31:0] bus_ad_i,
    // Initiator drive
    output logic [31:0] bus_ad_o,
    output logic [3:0] bus_cmd_byte_en_n_o,
    output logic bus_frame_n_o,
    output logic bus_initiator_ready_n_o,
    output logic bus_idsel_o
);
    // Idle bus at time zero
    initial begin
        bus_ad_o = 32'h0;
        bus_cmd_byte_en_n_o = 4'hf;
        bus_frame_n_o = 1'b1;
        bus_initiator_ready_n_o = 1'b1;
        bus_idsel_o = 1'b0;
    end
    // One transaction; resp 0 done, 1 disconnect, 2 abort, 3 unclaimed
    task automatic access(input logic [3:0] cmd, input logic [31:0] a,
        input logic [3:0] be, input logic [31:0] wd, input logic cfg,
        input logic burst, input logic b2b, output logic [31:0] rd,
        output logic [1:0] resp);
        resp = 2'h3;
        rd = 32'h0;
        // Two idle cycles unless chained right onto the last data edge
        if (!b2b) begin
            @(posedge mclk_i);
            bus_ad_o <= ~bus_ad_o;
            @(posedge mclk_i);
        end
        bus_frame_n_o <= 1'b0;
        bus_ad_o <= a;
        bus_cmd_byte_en_n_o <= cmd;
        bus_idsel_o <= cfg;
        @(posedge mclk_i);
        // A burst keeps frame low to ask for more
        bus_cmd_byte_en_n_o <= be;
        bus_ad_o <= cmd[0] ? wd : ~a;
        bus_initiator_ready_n_o <= 1'b0;
        bus_frame_n_o <= ~burst;
        bus_idsel_o <= 1'b0;
        for (int n = 0; n < 8; n++) begin
            @(posedge mclk_i);
            if (bus_target_ready_n_i === 1'b0) begin
                rd = bus_ad_i;
                resp = (bus_stop_n_i === 1'b0) ? 2'h1 : 2'h0;
                break;
            end
            if (bus_stop_n_i === 1'b0 && bus_devsel_n_i === 1'b1 &&
                bus_tgt_ctl_oe_i === 1'b1) begin
                resp = 2'h2;
                break;
            end
        end
        // Give up the bus; an aborted request is never repeated
        bus_initiator_ready_n_o <= 1'b1;
        if (burst) begin
            bus_frame_n_o <= 1'b1;
        end
    endtask
endmodule // pci_host_model
`default_nettype wire

// ### pci_term_cfg_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pci_term_cfg_tb;
    localparam logic [15:0] VC = 16'h4e21; // Arbitrary value
    localparam logic [15:0] DC = 16'h7b09; // Arbitrary value
    localparam logic [31:0] FIX = 32'h0280_0000; // Fixed status bits
    // Clock, reset and bus wires
    logic mclk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [31:0] dut_ad, host_ad, rd;
    logic ad_oe, devsel_n, trdy_n, stop_n, ctl_oe, frame_n, irdy_n, idsel;
    logic serr_n, serr_oe, allowed, retry, par_act, valid;
    logic [3:0] cbe_n;
    logic [1:0] resp;
    pci_term_pkg::mem_req_s req, last;
    // Master engine events: abort, master abort, disc, parity, serr
    logic [4:0] ev = 5'h0;
    logic active = 1'b0, disc_wd = 1'b0, grant_n = 1'b1;
    logic [31:0] mem_rdata = 32'h5a5a_1234;
    // Shared wire: the target wins while it drives
    wire logic [31:0] ad_wire = ad_oe ? dut_ad : host_ad;
    int errors = 0, check_count = 0, mem_cnt = 0, retry_cnt = 0;
    int serr_cnt = 0, par_cnt = 0;

    always #4 mclk_i = ~mclk_i;

    pci_term_cfg #(.VENDOR_CODE(VC), .DEVICE_CODE(DC)) i_pci_term_cfg (
        .mclk_i(mclk_i), .arst_n_i(arst_n_i), .bus_ad_i(ad_wire),
        .bus_ad_o(dut_ad), .bus_ad_oe_o(ad_oe),
        .bus_cmd_byte_en_n_i(cbe_n), .bus_frame_n_i(frame_n),
        .bus_initiator_ready_n_i(irdy_n), .bus_idsel_i(idsel),
        .bus_devsel_n_o(devsel_n), .bus_target_ready_n_o(trdy_n),
        .bus_stop_n_o(stop_n), .bus_tgt_ctl_oe_o(ctl_oe),
        .bus_system_error_n_o(serr_n), .bus_system_error_oe_o(serr_oe),
        .mst_active_i(active), .mst_target_abort_i(ev[0]),
        .mst_master_abort_i(ev[1]), .mst_disconnect_i(ev[2]),
        .mst_disc_with_data_i(disc_wd), .bus_grant_n_i(grant_n),
        .parity_err_i(ev[3]), .sys_err_req_i(ev[4]),
        .mst_allowed_o(allowed), .mst_retry_o(retry),
        .parity_act_o(par_act), .mem_req_o(req),
        .mem_req_valid_o(valid), .mem_rdata_i(mem_rdata));

    pci_host_model i_pci_host_model (
        .mclk_i(mclk_i), .bus_devsel_n_i(devsel_n),
        .bus_target_ready_n_i(trdy_n), .bus_stop_n_i(stop_n),
        .bus_tgt_ctl_oe_i(ctl_oe), .bus_ad_i(ad_wire),
        .bus_ad_o(host_ad), .bus_cmd_byte_en_n_o(cbe_n),
        .bus_frame_n_o(frame_n), .bus_initiator_ready_n_o(irdy_n),
        .bus_idsel_o(idsel));

    // Count one-cycle pulses; keep the last memory request
    always @(posedge mclk_i) begin
        if (valid === 1'b1) begin
            mem_cnt++;
            last = req;
        end
        retry_cnt += int'(retry === 1'b1);
        serr_cnt += int'(serr_oe === 1'b1);
        par_cnt += int'(par_act === 1'b1);
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Bus accesses
    task automatic cfg_rd(input logic [7:0] a, input logic b2b);
        i_pci_host_model.access(pci_term_pkg::CMD_CFG_RD, {24'h0, a},
            4'h0, 32'h0, 1'b1, 1'b0, b2b, rd, resp);
    endtask
    task automatic cfg_wr(input logic [7:0] a, input logic [3:0] be,
        input logic [31:0] d);
        i_pci_host_model.access(pci_term_pkg::CMD_CFG_WR, {24'h0, a},
            be, d, 1'b1, 1'b0, 1'b0, rd, resp);
    endtask
    task automatic mem(input logic [3:0] c, input logic [31:0] a,
        input logic [3:0] be, input logic burst);
        i_pci_host_model.access(c, a, be, a ^ 32'hc0de_0000, 1'b0,
            burst, 1'b0, rd, resp);
        repeat (2) @(posedge mclk_i);
    endtask
    // Event pulse
    task automatic fire(input logic [4:0] v);
        @(posedge mclk_i);
        ev <= v;
        @(posedge mclk_i);
        ev <= 5'h0;
        repeat (5) @(posedge mclk_i);
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (6) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        cfg_wr(8'h00, 4'h0, 32'hffff_ffff);
        cfg_rd(8'h00, 1'b0);
        chk(rd, {DC, VC});
        cfg_rd(8'h04, 1'b0);
        chk(rd, FIX);
        // Zero command half: memory space is not claimed
        mem(pci_term_pkg::CMD_MEM_WR, 32'h10, 4'h0, 1'b0);
        chk({30'h0, resp}, 32'h3);
        cfg_wr(8'h04, 4'h0, 32'h0000_ffff);
        cfg_rd(8'h04, 1'b1);
        chk(rd, FIX | 32'h146);
        chk({31'h0, allowed}, 32'h1);
        mem(pci_term_pkg::CMD_MEM_WR, 32'h10, 4'h0, 1'b0);
        chk(last.wdata, 32'hc0de_0010);
        // A burst is cut after its first word
        mem(pci_term_pkg::CMD_MEM_WR, 32'h20, 4'h0, 1'b1);
        chk({30'h0, resp}, 32'h1);
        // Local-bus byte enables
        for (int i = 0; i < 16; i++) begin
            mem(pci_term_pkg::CMD_MEM_RD, 32'h0010_0040, 4'(i), 1'b0);
            chk({30'h0, resp}, (i == 0 || i == 15 || i == 12 || i == 3 ||
                $countones(4'(~i)) == 1) ? 32'h0 : 32'h2);
        end
        chk(rd, mem_rdata);
        chk({last.addr[23:0], last.byte_en_n, 2'h0, last.local_bus,
             last.write}, 32'h1000_40f2);
        chk(32'(mem_cnt), 32'd10);
        // Status flags
        fire(5'h01);
        active <= 1'b1;
        fire(5'h0b);
        cfg_wr(8'h04, 4'h0, 32'h0000_0146);
        cfg_rd(8'h04, 1'b0);
        chk(rd, FIX | 32'hb100_0146);
        cfg_wr(8'h04, 4'h0, 32'h1000_0146);
        cfg_rd(8'h04, 1'b0);
        chk(rd, FIX | 32'ha100_0146);
        fire(5'h10);
        cfg_wr(8'h04, 4'h0, 32'hffff_0004);
        fire(5'h18);
        cfg_rd(8'h04, 1'b0);
        chk(rd, FIX | 32'hc000_0004);
        chk(32'(par_cnt + 4 * serr_cnt), 32'd5);
        chk({31'h0, serr_n}, 32'h0);
        // Retries
        grant_n <= 1'b0;
        fire(5'h04);
        disc_wd <= 1'b1;
        fire(5'h04);
        grant_n <= 1'b1;
        fire(5'h04);
        chk(32'(retry_cnt), 32'd2);
        cfg_wr(8'h04, 4'hc, 32'h0);
        grant_n <= 1'b0;
        fire(5'h04);
        chk(32'(retry_cnt), 32'd2);
        complete_run();
    end
    // Hang guard
    initial begin
        repeat (20000) @(posedge mclk_i);
        errors++;
        $display("[FAIL] %0t run did not finish", $time);
        complete_run();
    end
endmodule // pci_term_cfg_tb
`default_nettype wire
